// ### hw/fss_flash_map.vh
// Register map, field positions and timing constants of the flash self-write sequencer
`ifndef FSS_FLASH_MAP_VH
`define FSS_FLASH_MAP_VH

// ==========================================
// Register word indexes (byte address = 4 * index)
`define FSS_IDX_CTRL 3'h0
`define FSS_IDX_KEY 3'h1
`define FSS_IDX_PTR 3'h2
`define FSS_IDX_LATCH 3'h3
`define FSS_IDX_TBLWR 3'h4
`define FSS_IDX_STATUS 3'h5

// ==========================================
// Control register fields
`define FSS_CTRL_PMSEL 7
`define FSS_CTRL_CFGSEL 6
`define FSS_CTRL_ERASE 4
`define FSS_CTRL_WERR 3
`define FSS_CTRL_WRITE_EN 2
`define FSS_CTRL_WR 1

// ==========================================
// Status register fields
`define FSS_STAT_BUSY 0
`define FSS_STAT_HIPWR 1
`define FSS_STAT_ARMED 2

// ==========================================
// Table write pointer modes
`define FSS_TW_KEEP 2'h0
`define FSS_TW_POSTINC 2'h1
`define FSS_TW_POSTDEC 2'h2
`define FSS_TW_PREINC 2'h3

// ==========================================
// Unlock keys, erased byte and zero pointer/word constants
`define FSS_KEY_FIRST 8'h55
`define FSS_KEY_SECOND 8'hAA
`define FSS_ERASED_BYTE 8'hFF
`define FSS_PTR_RESET 22'h00_0000
`define FSS_ZERO_WORD 32'h0000_0000

// ==========================================
// Block geometry
`define FSS_SMALL_BLOCK 8'h40
`define FSS_LARGE_BLOCK 8'h80
`define FSS_ERASE_LOW_BITS 6

// ==========================================
// Timing
`define FSS_CLK_PERIOD_NS 8
`define FSS_PROG_TIME_NS 2000000

`endif

// ### hw/fss_flash_seq.v
// Flash self-timed row erase and block program sequencer with Avalon-MM register port
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fss_flash_map.vh"

module fss_flash_seq #(
  parameter LARGE_BLOCK = 0,
  parameter PROG_TIME_NS = `FSS_PROG_TIME_NS
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire devRst,
  input wire globalIntEnable,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [21:0] flashAddr,
  output reg [7:0] flashWrData,
  output reg flashWrite,
  output reg flashErase,
  output reg coreStall,
  output reg forceHighPower
);

  // ==========================================
  // Constants
  localparam [7:0] BLOCK_BYTES = LARGE_BLOCK ? `FSS_LARGE_BLOCK : `FSS_SMALL_BLOCK;
  localparam [7:0] LAST_IDX = BLOCK_BYTES - 8'h01;
  localparam integer PROG_CYCLES_RAW =
    (PROG_TIME_NS + `FSS_CLK_PERIOD_NS - 1) / `FSS_CLK_PERIOD_NS;
  localparam integer PROG_CYCLES = (PROG_CYCLES_RAW < 1) ? 1 : PROG_CYCLES_RAW;
  localparam [23:0] TIMER_LOAD = PROG_CYCLES[23:0] - 24'h00_0001;

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ERASE = 4'b0010;
  localparam [3:0] ST_PROG = 4'b0100;
  localparam [3:0] ST_TIMED = 4'b1000;

  // Holding index of a pointer within the current block
  function [6:0] holdIndex;
    input [21:0] ptr;
    begin
      holdIndex = LARGE_BLOCK ? ptr[6:0] : {1'b0, ptr[5:0]};
    end
  endfunction

  // ==========================================
  // State
  reg [3:0] state_q;
  reg [7:0] ctrl_q;
  reg [1:0] keyStage_q;
  reg [21:0] ptr_q;
  reg [7:0] latch_q;
  reg [127:0] holdLoaded_q;
  reg [7:0] holdMem [0:127];
  reg [7:0] streamIdx_q;
  reg [23:0] timer_q;
  reg [21:0] blockBase_q;
  reg opErase_q;

  wire busy = (state_q != ST_IDLE);
  wire accessReq = avs_read | avs_write;
  wire accept = accessReq & ~avs_waitrequest;
  wire wrAccept = avs_write & ~avs_waitrequest;
  wire [2:0] regIdx = avs_address[4:2];
  wire ctrlWr = wrAccept & (regIdx == `FSS_IDX_CTRL) & avs_byteenable[0];
  wire keyWr = wrAccept & (regIdx == `FSS_IDX_KEY) & avs_byteenable[0];
  wire tblWr = wrAccept & (regIdx == `FSS_IDX_TBLWR) & avs_byteenable[0];
  wire wrRequest = ctrlWr & avs_writedata[`FSS_CTRL_WR];
  wire armed = (keyStage_q == 2'h2);
  wire startOk = wrRequest & armed & ~globalIntEnable & avs_writedata[`FSS_CTRL_WRITE_EN]
    & avs_writedata[`FSS_CTRL_PMSEL] & ~avs_writedata[`FSS_CTRL_CFGSEL];
  wire startBad = wrRequest & ~startOk;
  wire opDone = (state_q == ST_TIMED) & (timer_q == 24'h00_0000);
  wire [21:0] ptrPlus = ptr_q + 22'h00_0001;
  wire [21:0] ptrMinus = ptr_q - 22'h00_0001;
  wire [21:0] twAddr = (avs_writedata[1:0] == `FSS_TW_PREINC) ? ptrPlus : ptr_q;
  wire [6:0] twIdx = holdIndex(twAddr);
  wire [6:0] streamSel = streamIdx_q[6:0];
  wire [21:0] blockMask = LARGE_BLOCK ? 22'h3F_FF80 : 22'h3F_FFC0;

  // ==========================================
  // Avalon slave: waitrequest drops for one cycle per access, held while busy
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      avs_waitrequest <= 1'b1;
    else if (accept | devRst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~(accessReq & ~busy); // Core stalls during long write
  end

  // Read data captured one cycle before the accepting edge
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      avs_readdata <= `FSS_ZERO_WORD;
    else if (avs_read & avs_waitrequest)
    begin
      case (regIdx)
        `FSS_IDX_CTRL: avs_readdata <= {24'h00_0000, ctrl_q};
        `FSS_IDX_PTR: avs_readdata <= {10'h000, ptr_q};
        `FSS_IDX_LATCH: avs_readdata <= {24'h00_0000, latch_q};
        `FSS_IDX_STATUS: avs_readdata <= {29'h0000_0000, armed, forceHighPower, busy};
        default: avs_readdata <= `FSS_ZERO_WORD; // Key, table write and unmapped read 0
      endcase
    end
  end

  // ==========================================
  // Unlock key tracker: every accepted register write advances, restarts (first key) or clears it
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      keyStage_q <= 2'h0;
    else if (devRst)
      keyStage_q <= 2'h0;
    else if (wrAccept)
    begin
      if (keyWr & (avs_writedata[7:0] == `FSS_KEY_FIRST))
        keyStage_q <= 2'h1;
      else if (keyWr & (keyStage_q == 2'h1) & (avs_writedata[7:0] == `FSS_KEY_SECOND))
        keyStage_q <= 2'h2;
      else
        keyStage_q <= 2'h0; // Any other write breaks the sequence
    end
  end

  // ==========================================
  // Control register
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_q <= 8'h00;
    else if (devRst)
    begin
      ctrl_q[`FSS_CTRL_WR] <= 1'b0;
      ctrl_q[`FSS_CTRL_ERASE] <= 1'b0;
      ctrl_q[`FSS_CTRL_WRITE_EN] <= 1'b0;
      if (busy)
        ctrl_q[`FSS_CTRL_WERR] <= 1'b1; // Select bits kept for tracing
    end
    else if (opDone)
    begin
      ctrl_q[`FSS_CTRL_WR] <= 1'b0;
      if (opErase_q)
        ctrl_q[`FSS_CTRL_ERASE] <= 1'b0;
    end
    else if (ctrlWr)
    begin
      ctrl_q[`FSS_CTRL_PMSEL] <= avs_writedata[`FSS_CTRL_PMSEL];
      ctrl_q[`FSS_CTRL_CFGSEL] <= avs_writedata[`FSS_CTRL_CFGSEL];
      ctrl_q[`FSS_CTRL_ERASE] <= avs_writedata[`FSS_CTRL_ERASE];
      ctrl_q[`FSS_CTRL_WRITE_EN] <= avs_writedata[`FSS_CTRL_WRITE_EN];
      ctrl_q[`FSS_CTRL_WERR] <= avs_writedata[`FSS_CTRL_WERR] | startBad;
      if (startOk)
        ctrl_q[`FSS_CTRL_WR] <= 1'b1; // Software can only set it
    end
  end

  // ==========================================
  // Table pointer and table latch
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ptr_q <= `FSS_PTR_RESET;
      latch_q <= 8'h00;
    end
    else if (wrAccept & (regIdx == `FSS_IDX_PTR))
    begin
      if (avs_byteenable[0])
        ptr_q[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1])
        ptr_q[15:8] <= avs_writedata[15:8];
      if (avs_byteenable[2])
        ptr_q[21:16] <= avs_writedata[21:16];
    end
    else if (wrAccept & (regIdx == `FSS_IDX_LATCH) & avs_byteenable[0])
      latch_q <= avs_writedata[7:0];
    else if (tblWr)
    begin
      case (avs_writedata[1:0])
        `FSS_TW_POSTINC: ptr_q <= ptrPlus;
        `FSS_TW_POSTDEC: ptr_q <= ptrMinus;
        `FSS_TW_PREINC: ptr_q <= ptrPlus;
        default: ptr_q <= ptr_q;
      endcase
    end
  end

  // ==========================================
  // Holding registers: loaded flags give FFh defaults without clearing the array
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      holdLoaded_q <= 128'h0;
    else if (devRst)
      holdLoaded_q <= 128'h0;
    else if ((state_q == ST_PROG) & (streamIdx_q == LAST_IDX))
      holdLoaded_q <= 128'h0; // Back to FFh after program
    else if (tblWr)
      holdLoaded_q[twIdx] <= 1'b1;
  end

  // Byte storage written by table writes, short write only
  always @(posedge clk_sys)
  begin
    if (tblWr)
      holdMem[twIdx] <= latch_q;
  end

  // ==========================================
  // Sequencer: erase pulse or block stream, then the internal timer
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      streamIdx_q <= 8'h00;
      timer_q <= 24'h00_0000;
      blockBase_q <= `FSS_PTR_RESET;
      opErase_q <= 1'b0;
    end
    else if (devRst)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          streamIdx_q <= 8'h00;
          if (startOk)
          begin
            blockBase_q <= ptr_q & blockMask; // Upper bits pick the block
            opErase_q <= avs_writedata[`FSS_CTRL_ERASE];
            if (avs_writedata[`FSS_CTRL_ERASE])
              state_q <= ST_ERASE;
            else
              state_q <= ST_PROG;
          end
        end
        ST_ERASE:
        begin
          timer_q <= TIMER_LOAD;
          state_q <= ST_TIMED;
        end
        ST_PROG:
        begin
          streamIdx_q <= streamIdx_q + 8'h01; // Whole block is walked
          if (streamIdx_q == LAST_IDX)
          begin
            timer_q <= TIMER_LOAD;
            state_q <= ST_TIMED;
          end
        end
        ST_TIMED:
        begin
          if (timer_q == 24'h00_0000)
            state_q <= ST_IDLE; // Timer ends the long write
          else
            timer_q <= timer_q - 24'h00_0001;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Flash array strobes
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flashAddr <= `FSS_PTR_RESET;
      flashWrData <= `FSS_ERASED_BYTE;
      flashWrite <= 1'b0;
      flashErase <= 1'b0;
    end
    else
    begin
      flashErase <= ~devRst & (state_q == ST_ERASE);
      flashWrite <= 1'b0;
      if (state_q == ST_ERASE)
        flashAddr <= blockBase_q;
      else if (state_q == ST_PROG)
      begin
        flashAddr <= blockBase_q | {15'h0000, streamSel};
        flashWrData <= holdMem[streamSel];
        // Unloaded or FFh bytes leave the flash byte alone
        flashWrite <= ~devRst & holdLoaded_q[streamSel]
          & (holdMem[streamSel] != `FSS_ERASED_BYTE);
      end
    end
  end

  // ==========================================
  // Core stall and oscillator power request
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      coreStall <= 1'b0;
      forceHighPower <= 1'b0;
    end
    else
    begin
      coreStall <= ~devRst & (startOk | (busy & ~opDone));
      if (startOk)
        forceHighPower <= 1'b1;
    end
  end

endmodule // fss_flash_seq

// ### testbench/fss_flash_seq_assertions.sv
// Port checker for the flash self-write sequencer
`timescale 1ns/1ps
// ==========
// Checker
module fss_flash_seq_checker #(
  parameter LARGE_BLOCK = 0
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire avs_waitrequest,
  input wire [21:0] flashAddr,
  input wire [7:0] flashWrData,
  input wire flashWrite,
  input wire flashErase,
  input wire coreStall,
  input wire forceHighPower
);
  // One clock domain, cleared by the system reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  property p_ep; flashErase |=> !flashErase && coreStall; endproperty
  a_ep: assert property (p_ep) else $error("erase strobe too long");
  property p_st; flashWrite |-> coreStall && !flashErase; endproperty
  a_st: assert property (p_st) else $error("byte write outside stall");
  property p_eb;
    flashErase |-> (flashAddr & (LARGE_BLOCK ? 22'h00_007F : 22'h00_003F)) == 22'h00_0000;
  endproperty
  a_eb: assert property (p_eb) else $error("erase base not aligned");
  property p_ff; flashWrite |-> flashWrData != 8'hFF; endproperty
  a_ff: assert property (p_ff) else $error("default byte written");
  property p_hp; $rose(coreStall) |=> forceHighPower; endproperty
  a_hp: assert property (p_hp) else $error("no high power mode");
  property p_bw; coreStall |-> avs_waitrequest; endproperty
  a_bw: assert property (p_bw) else $error("access answered while busy");
  property p_sm; $rose(coreStall) |-> coreStall [*8]; endproperty
  a_sm: assert property (p_sm) else $error("timed cycle too short");
  property p_ak; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_ak: assert property (p_ak) else $error("waitrequest low too long");
endmodule // fss_flash_seq_checker

bind fss_flash_seq fss_flash_seq_checker #(.LARGE_BLOCK(LARGE_BLOCK)) fss_flash_seq_checker_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_waitrequest(avs_waitrequest),
  .flashAddr(flashAddr), .flashWrData(flashWrData), .flashWrite(flashWrite),
  .flashErase(flashErase), .coreStall(coreStall), .forceHighPower(forceHighPower));

// ### testbench/fss_flash_model.sv
// Behavioural flash array block behind the sequencer's flash port
`timescale 1ns/1ps
// ==========
// Flash model
module fss_flash_model (
  input wire clk_sys,
  input wire [21:0] flashAddr,
  input wire [7:0] flashWrData,
  input wire flashWrite,
  input wire flashErase
);
  reg [7:0] mem [0:63];
  reg [21:0] lastEr;
  integer nWr, nEr, i;
  // Blank at zero so an erase shows up
  initial
  begin
    nWr = 0;
    nEr = 0;
    lastEr = 22'h00_0000;
    for (i = 0; i < 64; i = i + 1) mem[i] = 8'h00;
  end
  // Erase fills the block, a byte write can only clear bits
  always @(posedge clk_sys)
  begin
    if (flashErase)
    begin
      nEr <= nEr + 1;
      lastEr <= flashAddr;
      for (i = 0; i < 64; i = i + 1) mem[i] <= 8'hFF;
    end
    if (flashWrite)
    begin
      nWr <= nWr + 1;
      mem[flashAddr[5:0]] <= mem[flashAddr[5:0]] & flashWrData;
    end
  end
endmodule // fss_flash_model

// ### testbench/tb_fss_flash_seq.sv
// Self-checking bench of the flash self-write sequencer
`timescale 1ns/1ps
`include "fss_flash_map.vh"
// ==========
// Bench top
module tb_fss_flash_seq;
  reg clk_sys, sys_rst, devRst, globalIntEnable, avs_read, avs_write;
  reg [4:0] avs_address;
  reg [31:0] avs_writedata, rdData;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, flashWrite, flashErase, coreStall, forceHighPower;
  wire [21:0] flashAddr;
  wire [7:0] flashWrData;
  integer miscompares, tests_run, wrBase;
  // Design with a short programming time, and the flash behind it
  fss_flash_seq #(.PROG_TIME_NS(80)) fss_flash_seq_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .devRst(devRst), .globalIntEnable(globalIntEnable), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flashAddr(flashAddr), .flashWrData(flashWrData),
    .flashWrite(flashWrite), .flashErase(flashErase), .coreStall(coreStall),
    .forceHighPower(forceHighPower));
  fss_flash_model fss_flash_model_inst (.clk_sys(clk_sys), .flashAddr(flashAddr),
    .flashWrData(flashWrData), .flashWrite(flashWrite), .flashErase(flashErase));
  // 125 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // One bus access, held until waitrequest is sampled low at a rising edge
  task acc(input rd, input [2:0] idx, input [31:0] d);
    begin
      @(posedge clk_sys);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= {idx, 2'b00};
      avs_writedata <= d;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      rdData = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        miscompares = miscompares + 1;
        $display("BAD %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task rdc(input [2:0] idx, input [31:0] exp);
    begin
      acc(1'b1, idx, 32'h0000_0000);
      chk("reg", exp, rdData);
    end
  endtask
  // Both keys, then the control word
  task go(input [31:0] ct);
    begin
      acc(1'b0, `FSS_IDX_KEY, 32'h0000_0055);
      acc(1'b0, `FSS_IDX_KEY, 32'h0000_00AA);
      acc(1'b0, `FSS_IDX_CTRL, ct);
    end
  endtask
  // Latch a byte and table-write it with post-increment
  task ld(input [7:0] b);
    begin
      acc(1'b0, `FSS_IDX_LATCH, {24'h00_0000, b});
      acc(1'b0, `FSS_IDX_TBLWR, 32'h0000_0001);
    end
  endtask
  task give_verdict;
    begin
      $display("Checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares = miscompares + 1;
    give_verdict;
  end
  // Test sequence
  initial
  begin
    sys_rst = 1'b1;
    devRst = 1'b0;
    globalIntEnable = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    miscompares = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdc(3'h7, 32'h0000_0000);
    acc(1'b0, `FSS_IDX_PTR, 32'h0000_1234);
    acc(1'b0, `FSS_IDX_CTRL, 32'h0000_0094);
    go(32'h0000_0096);
    rdc(`FSS_IDX_CTRL, 32'h0000_0084);
    chk("erase", 32'h0000_1200, {10'h000, fss_flash_model_inst.lastEr});
    chk("nErase", 1, fss_flash_model_inst.nEr);
    acc(1'b0, `FSS_IDX_PTR, 32'h0000_1200);
    ld(8'h12);
    ld(8'hFF);
    ld(8'h0F);
    go(32'h0000_0086);
    rdc(`FSS_IDX_CTRL, 32'h0000_0084);
    chk("flash0", 32'h0000_0012, {24'h00_0000, fss_flash_model_inst.mem[0]});
    chk("flash1", 32'h0000_00FF, {24'h00_0000, fss_flash_model_inst.mem[1]});
    chk("flash2", 32'h0000_000F, {24'h00_0000, fss_flash_model_inst.mem[2]});
    chk("nWrite", 2, fss_flash_model_inst.nWr);
    acc(1'b1, `FSS_IDX_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0002, rdData & 32'h0000_0003);
    wrBase = fss_flash_model_inst.nWr;
    go(32'h0000_0086);
    rdc(`FSS_IDX_CTRL, 32'h0000_0084);
    chk("nWrite", wrBase, fss_flash_model_inst.nWr);
    ld(8'h00);
    acc(1'b0, `FSS_IDX_KEY, 32'h0000_0055);
    acc(1'b0, `FSS_IDX_PTR, 32'h0000_1200);
    acc(1'b0, `FSS_IDX_KEY, 32'h0000_00AA);
    acc(1'b0, `FSS_IDX_CTRL, 32'h0000_0086);
    rdc(`FSS_IDX_CTRL, 32'h0000_008C);
    acc(1'b0, `FSS_IDX_CTRL, 32'h0000_0084);
    globalIntEnable <= 1'b1;
    go(32'h0000_0086);
    rdc(`FSS_IDX_CTRL, 32'h0000_008C);
    chk("nWrite", wrBase, fss_flash_model_inst.nWr);
    globalIntEnable <= 1'b0;
    acc(1'b0, `FSS_IDX_CTRL, 32'h0000_0084);
    go(32'h0000_0086);
    rdc(`FSS_IDX_CTRL, 32'h0000_0084);
    chk("flash3", 32'h0000_0000, {24'h00_0000, fss_flash_model_inst.mem[3]});
    ld(8'h00);
    go(32'h0000_0086);
    repeat (20) @(posedge clk_sys);
    devRst <= 1'b1;
    @(posedge clk_sys);
    devRst <= 1'b0;
    rdc(`FSS_IDX_CTRL, 32'h0000_0088);
    give_verdict;
  end
endmodule // tb_fss_flash_seq
